// ---- obc_core.sv ----
// Core-side driver: takes software orders and runs the option-byte sequences on the controller
`timescale 1ns/100ps
module obc_core import obc_pkg::*; (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  obc_if.core              bus,
  input  wire logic [4:0]  swAddr,
  input  wire logic [31:0] swWdata,
  input  wire logic        swWr,
  input  wire logic        swRd,
  output logic [31:0]      swRdata
);
  obc_hstate_type hstate;
  logic [1:0]     op;
  logic           rldAfter;
  logic           done;
  logic [1:0]     dIdx;
  logic [31:0]    dLo;
  logic [31:0]    dHi;
  logic [31:0]    ob1Val;
  logic [31:0]    result;

  wire        hIdle  = (hstate == HS_IDLE);
  wire        swSel  = swWr & hIdle;
  wire        launch = swSel & (swAddr == SW_CMD_OFS) & ((swWdata[1:0] != OP_NONE) | swWdata[2]);
  wire        devBusy = |(bus.regRdata & ST_BUSY);
  // Read data stand one cycle after the strobe, so a check state waits while the strobe is still out
  wire        rdPend = bus.regRd;
  wire [31:0] dwAddr = OB0_BASE | {27'h0, dIdx, 3'h0};
  // The reserved byte pair in the last double word is forced to ones and its complement
  wire [31:0] hiWord = (dIdx == 2'h2) ? {dHi[31:16], 16'h00ff} : dHi;
  wire [31:0] swMux  = (swAddr == SW_CMD_OFS) ? {27'h0, rldAfter, op, done, ~hIdle} :
                       (swAddr == SW_IDX_OFS) ? {30'h0, dIdx} :
                       (swAddr == SW_DLO_OFS) ? dLo :
                       (swAddr == SW_DHI_OFS) ? dHi :
                       (swAddr == SW_OB1_OFS) ? ob1Val :
                       (swAddr == SW_RES_OFS) ? result : 32'h0;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dIdx <= 2'h0;
      dLo <= 32'h0;
      dHi <= 32'h0;
      ob1Val <= 32'h0;
      swRdata <= 32'h0;
    end else begin
      if (swSel & (swAddr == SW_IDX_OFS)) begin
        dIdx <= swWdata[1:0];
      end
      if (swSel & (swAddr == SW_DLO_OFS)) begin
        dLo <= swWdata;
      end
      if (swSel & (swAddr == SW_DHI_OFS)) begin
        dHi <= swWdata;
      end
      if (swSel & (swAddr == SW_OB1_OFS)) begin
        ob1Val <= swWdata & ~OB1_START;
      end
      swRdata <= swRd ? swMux : 32'h0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hstate <= HS_IDLE;
      op <= OP_NONE;
      rldAfter <= 1'b0;
      done <= 1'b0;
      result <= 32'h0;
      bus.regAddr <= 5'h00;
      bus.regWdata <= 32'h0;
      bus.regWr <= 1'b0;
      bus.regRd <= 1'b0;
      bus.dbusAddr <= 32'h0;
      bus.dbusWdata <= 32'h0;
      bus.dbusWr <= 1'b0;
    end else begin
      bus.regWr <= 1'b0;
      bus.regRd <= 1'b0;
      bus.dbusWr <= 1'b0;
      unique case (hstate)
        HS_IDLE: begin
          if (launch) begin
            op <= swWdata[1:0];
            rldAfter <= swWdata[2];
            done <= 1'b0;
            hstate <= HS_POLL;
          end
        end
        HS_POLL, HS_WAIT: begin
          bus.regAddr <= STAT_OFS;
          bus.regRd <= 1'b1;
          hstate <= (hstate == HS_POLL) ? HS_PCHK : HS_WACK;
        end
        HS_PCHK: begin
          if (rdPend) begin
            hstate <= HS_PCHK;
          end else if (devBusy) begin
            hstate <= HS_POLL;
          end else begin
            hstate <= (op == OP_NONE) ? HS_RLD : HS_WEN;
          end
        end
        HS_WEN: begin
          bus.regAddr <= CTL_OFS;
          bus.regWdata <= CTL_WEN;
          bus.regWr <= 1'b1;
          hstate <= HS_WRD;
        end
        HS_WRD: begin
          bus.regAddr <= CTL_OFS;
          bus.regRd <= 1'b1;
          hstate <= HS_WCHK;
        end
        HS_WCHK: hstate <= rdPend ? HS_WCHK : |(bus.regRdata & CTL_WEN) ? HS_CMD : HS_WRD;
        HS_CMD: begin
          bus.regWr <= 1'b1;
          if (op == OP_ERASE) begin
            bus.regAddr <= CTL_OFS;
            bus.regWdata <= CTL_WEN | CTL_ER | CTL_START;
            hstate <= HS_WAIT;
          end else if (op == OP_PROG) begin
            bus.regAddr <= CTL_OFS;
            bus.regWdata <= CTL_WEN | CTL_PG;
            hstate <= HS_LO;
          end else begin
            bus.regAddr <= OB1CS_OFS;
            bus.regWdata <= ob1Val;
            hstate <= HS_GO1;
          end
        end
        HS_LO: begin
          bus.dbusAddr <= dwAddr;
          bus.dbusWdata <= dLo;
          bus.dbusWr <= 1'b1;
          hstate <= HS_HI;
        end
        HS_HI: begin
          bus.dbusAddr <= dwAddr | 32'h0000_0004;
          bus.dbusWdata <= hiWord;
          bus.dbusWr <= 1'b1;
          hstate <= HS_WAIT;
        end
        HS_GO1: begin
          bus.regAddr <= OB1CS_OFS;
          bus.regWdata <= ob1Val | OB1_START;
          bus.regWr <= 1'b1;
          hstate <= HS_WAIT;
        end
        HS_WACK: begin
          if (rdPend) begin
            hstate <= HS_WACK;
          end else if (devBusy) begin
            hstate <= HS_WAIT;
          end else begin
            result <= bus.regRdata;
            bus.regAddr <= STAT_OFS;
            bus.regWdata <= ST_PROGRAM_ERROR_FLAG | ST_SEQERR | ST_END;
            bus.regWr <= 1'b1;
            done <= ~rldAfter;
            hstate <= rldAfter ? HS_RLD : HS_IDLE;
          end
        end
        HS_RLD: begin
          bus.regAddr <= CTL_OFS;
          bus.regWdata <= CTL_WEN | CTL_RLD;
          bus.regWr <= 1'b1;
          done <= 1'b1;
          hstate <= HS_IDLE;
        end
        default: hstate <= HS_IDLE;
      endcase
    end
  end
endmodule

// ---- obc_device.sv ----
// Option-byte controller: registers, option flash storage, reload, checks and decode
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/100ps
module obc_device import obc_pkg::*; (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        porRst_n,
  obc_if.dev               bus,
  input  wire logic        bootMain,
  input  wire logic        bank1Void,
  output logic             endIrq,
  output logic             bootBank1,
  output logic             copyBank1,
  output logic [1:0]       securityLevel,
  output logic             standbyNoReset,
  output logic             deepsleepNoReset,
  output logic             watchdogSoftSelect,
  output logic             brownoutEnable,
  output logic [31:0]      bank0ProtectMask,
  output logic [7:0]       bank1ProtectMask,
  output logic [7:0]       dataflashProtectMask,
  output logic [15:0]      userData,
  output logic [1:0]       dataFlashSize
);
  obc_dstate_type state;
  obc_dstate_type next_state;
  logic [8:0]     cnt;
  logic [8:0]     next_cnt;
  logic [63:0]    obMem [0:OB0_DWORDS-1];
  logic [63:0]    ob1Mem;
  logic           wen;
  logic           pgCmd;
  logic           erCmd;
  logic           end_interrupt_enable;
  logic           program_error_flag;
  logic           seqErr;
  logic           endFlag;
  logic [31:0]    ob1Stage;
  logic [31:0]    ob1Lo;
  logic           opt1_locked_flag;
  logic           opt1_mismatch_flag;
  logic           ob0Err;
  logic [7:0]     userByte;
  logic [31:0]    halfLo;
  logic           halfValid;
  logic [1:0]     halfIdx;
  logic [63:0]    progData;
  logic [1:0]     progIdx;
  logic [31:0]    rdMux;

  wire [31:0]  wd      = bus.regWdata;
  wire         idle    = (state == DS_IDLE);
  wire         lastCyc = (cnt == 9'h001);
  wire         wrCtl   = bus.regWr & (bus.regAddr == CTL_OFS);
  wire         wrStat  = bus.regWr & (bus.regAddr == STAT_OFS);
  wire         wrOb1   = bus.regWr & (bus.regAddr == OB1CS_OFS);
  wire         wStart  = |(wd & CTL_START);
  wire         wEr     = |(wd & CTL_ER);
  wire         wPg     = |(wd & CTL_PG);
  wire         erGo    = wrCtl & wStart & wEr & ~wPg & |(wd & CTL_WEN) & idle;
  wire         rldGo   = wrCtl & |(wd & CTL_RLD) & idle;
  // Option-1 start checks: lock, enable, other commands, reserved bit, size and partition
  wire [3:0]   wPart   = wd[PART_LSB+:4];
  wire         partOk  = (wPart == PART_64K) | (wPart == PART_32K) | (wPart == PART_NONE);
  wire         ob1Go   = wrOb1 & |(wd & OB1_START) & idle;
  wire         ob1Bad  = opt1_locked_flag | ~wen | pgCmd | erCmd | |(wd & OB1_RSV)
                         | (wd[SIZE_LSB+:4] != EXT_SIZE_OK) | ~partOk;
  wire         sizeChg = (wd[PART_LSB+:8] != ob1Mem[PART_LSB+:8]);
  wire [31:0]  ob1New  = {ob1Stage[31:4], ob1Stage[3], 3'h0};
  // Data bus writes into the option-0 block: low word first, then high word of the same double word
  wire         inOb0   = bus.dbusWr & (bus.dbusAddr[31:5] == OB0_BASE[31:5]) & (bus.dbusAddr[4:3] != 2'h3);
  wire [1:0]   dwIdx   = bus.dbusAddr[4:3];
  wire         hiHalf  = bus.dbusAddr[2];
  wire         progHit = inOb0 & hiHalf & halfValid & (halfIdx == dwIdx) & pgCmd & ~erCmd & wen & idle;
  wire         notBlank = (obMem[dwIdx] != {64{1'b1}});
  wire         progGo  = progHit & ~notBlank;
  wire         pgErrSet = progHit & notBlank;
  wire         seqSet  = (wrCtl & wStart & wEr & wPg) | (ob1Go & ob1Bad) | (inOb0 & pgCmd & erCmd);
  wire         opDone  = lastCyc & ((state == DS_ERASE) | (state == DS_PROG) | (state == DS_OB1PG));
  // Reload path: each of the first eleven option-0 byte pairs has its value byte checked against its complement byte
  wire [191:0] obFlat  = {obMem[2], obMem[1], obMem[0]};
  wire [10:0]  pairBad;
  wire [87:0]  pairVal;
  wire [1:0]   secDec  = (pairVal[7:0] == SPC_NONE) ? SEC_NONE :
                         (pairVal[7:0] == SPC_HIGH) ? SEC_HIGH : SEC_LOW;
  wire [3:0]   ldPart  = ob1Mem[PART_LSB+:4];
  wire [1:0]   dfDec   = (ldPart == PART_64K) ? DF_64K : (ldPart == PART_32K) ? DF_32K : DF_NONE;
  wire [31:0]  ctlWord = {26'h0, wen, end_interrupt_enable, 2'h0, erCmd, pgCmd};
  wire [31:0]  statWord = {26'h0, endFlag, 2'h0, seqErr, program_error_flag, ~idle};
  wire [31:0]  ob1Word = {ob1Lo[31:3], opt1_mismatch_flag, opt1_locked_flag, 1'b0};
  wire [31:0]  obstWord = {userData, userByte, 5'h0, securityLevel, ob0Err};

  genvar g;
  generate
    for (g = 0; g < 11; g++) begin : gPair
      assign pairBad[g] = (obFlat[16*g+:8] != ~obFlat[16*g+8+:8]);
      assign pairVal[8*g+:8] = pairBad[g] ? 8'hff : obFlat[16*g+:8];
    end
    for (g = 0; g < OB0_DWORDS; g++) begin : gMem
      always_ff @(posedge core_clk) begin
        if (!porRst_n) begin
          obMem[g] <= OB0_FACTORY[64*g+:64];
        end else if (state == DS_ERASE && lastCyc) begin
          obMem[g] <= {64{1'b1}};
        end else if (state == DS_PROG && lastCyc && progIdx == 2'(g)) begin
          obMem[g] <= progData;
        end
      end
    end
  endgenerate

  assign rdMux = (bus.regAddr == CTL_OFS)    ? ctlWord :
                 (bus.regAddr == STAT_OFS)   ? statWord :
                 (bus.regAddr == OB1CS_OFS)  ? ob1Word :
                 (bus.regAddr == OBSTAT_OFS) ? obstWord :
                 (bus.regAddr == WP0_OFS)    ? bank0ProtectMask :
                 (bus.regAddr == WP1_OFS)    ? {16'h0, dataflashProtectMask, bank1ProtectMask} : 32'h0;

  assign standbyNoReset     = userByte[2];
  assign deepsleepNoReset   = userByte[1];
  assign watchdogSoftSelect = userByte[0];

  always_comb begin
    next_state = state;
    next_cnt = cnt - 9'h001;
    unique case (state)
      DS_IDLE: begin
        next_cnt = cnt;
        if (erGo) begin
          next_state = DS_ERASE;
          next_cnt = ERASE_CYCLES;
        end else if (progGo) begin
          next_state = DS_PROG;
          next_cnt = PROG_CYCLES;
        end else if (ob1Go & ~ob1Bad) begin
          next_state = sizeChg ? DS_EXTER : DS_OB1PG;
          next_cnt = sizeChg ? EXT_ERASE_CYCLES : PROG_CYCLES;
        end else if (rldGo) begin
          next_state = DS_LOAD;
        end
      end
      DS_LOAD: next_state = DS_IDLE;
      DS_EXTER: begin
        if (lastCyc) begin
          next_state = DS_OB1PG;
          next_cnt = PROG_CYCLES;
        end
      end
      DS_ERASE, DS_PROG, DS_OB1PG: begin
        if (lastCyc) begin
          next_state = DS_IDLE;
        end
      end
      default: next_state = DS_IDLE;
    endcase
  end

  // Option-1 flash copy; only the load state after reset or reload moves it into the live fields
  always_ff @(posedge core_clk) begin
    if (!porRst_n) begin
      ob1Mem <= OB1_FACTORY;
    end else if (state == DS_OB1PG && lastCyc) begin
      ob1Mem <= {~ob1New, ob1New};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= DS_LOAD;
      cnt <= 9'h000;
      wen <= 1'b0;
      pgCmd <= 1'b0;
      erCmd <= 1'b0;
      end_interrupt_enable <= 1'b0;
      program_error_flag <= 1'b0;
      seqErr <= 1'b0;
      endFlag <= 1'b0;
      endIrq <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      if (wrCtl) begin
        wen <= |(wd & CTL_WEN);
        pgCmd <= wPg;
        erCmd <= wEr;
        end_interrupt_enable <= |(wd & CTL_END_INTERRUPT_ENABLE);
      end
      program_error_flag <= pgErrSet | (program_error_flag & ~(wrStat & |(wd & ST_PROGRAM_ERROR_FLAG)));
      seqErr <= seqSet | (seqErr & ~(wrStat & |(wd & ST_SEQERR)));
      endFlag <= opDone | (endFlag & ~(wrStat & |(wd & ST_END)));
      endIrq <= endFlag & end_interrupt_enable;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      halfValid <= 1'b0;
      halfLo <= 32'h0;
      halfIdx <= 2'h0;
      progData <= 64'h0;
      progIdx <= 2'h0;
      ob1Stage <= 32'h0;
    end else begin
      if (inOb0) begin
        halfValid <= ~hiHalf;
      end
      if (inOb0 & ~hiHalf) begin
        halfLo <= bus.dbusWdata;
        halfIdx <= dwIdx;
      end
      if (progGo) begin
        progData <= {bus.dbusWdata, halfLo};
        progIdx <= dwIdx;
      end
      if (ob1Go & ~ob1Bad) begin
        ob1Stage <= wd;
      end
    end
  end

  // Live option values, refreshed only in the load state after reset or reload
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ob0Err <= 1'b0;
      securityLevel <= SEC_NONE;
      userByte <= 8'h00;
      brownoutEnable <= 1'b0;
      userData <= 16'h0;
      bank0ProtectMask <= 32'h0;
      bank1ProtectMask <= 8'h0;
      dataflashProtectMask <= 8'h0;
      ob1Lo <= 32'h0;
      opt1_locked_flag <= 1'b0;
      opt1_mismatch_flag <= 1'b0;
      dataFlashSize <= DF_NONE;
    end else if (state == DS_LOAD) begin
      ob0Err <= |pairBad;
      securityLevel <= secDec;
      userByte <= pairVal[15:8];
      brownoutEnable <= ~pairVal[15];
      userData <= pairVal[31:16];
      bank0ProtectMask <= pairVal[63:32];
      bank1ProtectMask <= pairVal[71:64];
      dataflashProtectMask <= pairVal[79:72];
      ob1Lo <= ob1Mem[31:0];
      opt1_locked_flag <= (ob1Mem[LOCK_LSB+:16] == LOCK_PATTERN);
      opt1_mismatch_flag <= (ob1Mem[63:32] != ~ob1Mem[31:0]);
      dataFlashSize <= dfDec;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bootBank1 <= 1'b0;
      copyBank1 <= 1'b0;
      bus.regRdata <= 32'h0;
    end else begin
      bootBank1 <= bootMain & userByte[4] & ~userByte[3] & ~bank1Void;
      copyBank1 <= bootMain & ~userByte[4] & ~userByte[3];
      bus.regRdata <= bus.regRd ? rdMux : 32'h0;
    end
  end
endmodule

// ---- obc_if.sv ----
// Register port and data bus between the processor core and the option-byte controller
`timescale 1ns/100ps
interface obc_if;
  logic [4:0]  regAddr;
  logic [31:0] regWdata;
  logic        regWr;
  logic        regRd;
  logic [31:0] regRdata;
  logic [31:0] dbusAddr;
  logic [31:0] dbusWdata;
  logic        dbusWr;

  modport dev (input regAddr, input regWdata, input regWr, input regRd, output regRdata,
               input dbusAddr, input dbusWdata, input dbusWr);
  modport core (output regAddr, output regWdata, output regWr, output regRd, input regRdata,
                output dbusAddr, output dbusWdata, output dbusWr);
endinterface

// ---- obc_pkg.sv ----
// Shared constants and types for the option-byte controller and its core-side driver
package obc_pkg;
  // Controller register offsets on the interface register port
  localparam logic [4:0] CTL_OFS    = 5'h00;
  localparam logic [4:0] STAT_OFS   = 5'h04;
  localparam logic [4:0] OB1CS_OFS  = 5'h08;
  localparam logic [4:0] OBSTAT_OFS = 5'h0c;
  localparam logic [4:0] WP0_OFS    = 5'h10;
  localparam logic [4:0] WP1_OFS    = 5'h14;
  // Control word bits
  localparam logic [31:0] CTL_PG    = 32'h0000_0001;
  localparam logic [31:0] CTL_ER    = 32'h0000_0002;
  localparam logic [31:0] CTL_START = 32'h0000_0004;
  localparam logic [31:0] CTL_RLD   = 32'h0000_0008;
  localparam logic [31:0] CTL_END_INTERRUPT_ENABLE = 32'h0000_0010;
  localparam logic [31:0] CTL_WEN   = 32'h0000_0020;
  // Status word bits, flags clear by writing one
  localparam logic [31:0] ST_BUSY   = 32'h0000_0001;
  localparam logic [31:0] ST_PROGRAM_ERROR_FLAG  = 32'h0000_0002;
  localparam logic [31:0] ST_SEQERR = 32'h0000_0004;
  localparam logic [31:0] ST_END    = 32'h0000_0020;
  // Option-byte-1 control/status word
  localparam logic [31:0] OB1_START = 32'h0000_0001;
  localparam logic [31:0] OB1_LOAD  = 32'h0000_0008;
  localparam logic [31:0] OB1_RSV   = 32'h0000_8000;
  localparam int          PART_LSB  = 4;
  localparam int          SIZE_LSB  = 8;
  localparam int          LOCK_LSB  = 16;
  localparam logic [15:0] LOCK_PATTERN = 16'h33cc;
  localparam logic [3:0]  EXT_SIZE_OK  = 4'hf;
  localparam logic [3:0]  PART_64K     = 4'h0;
  localparam logic [3:0]  PART_32K     = 4'h1;
  localparam logic [3:0]  PART_NONE    = 4'hf;
  // Decoded data-flash size and security level codes
  localparam logic [1:0]  DF_NONE  = 2'h0;
  localparam logic [1:0]  DF_32K   = 2'h1;
  localparam logic [1:0]  DF_64K   = 2'h2;
  localparam logic [7:0]  SPC_NONE = 8'ha5;
  localparam logic [7:0]  SPC_HIGH = 8'hcc;
  localparam logic [1:0]  SEC_NONE = 2'h0;
  localparam logic [1:0]  SEC_LOW  = 2'h1;
  localparam logic [1:0]  SEC_HIGH = 2'h2;
  // Option-byte-0 block: three double words from this absolute base
  localparam logic [31:0]  OB0_BASE    = 32'h1fff_f800;
  localparam int           OB0_DWORDS  = 3;
  localparam logic [191:0] OB0_FACTORY = 192'hffff_00ff_00ff_00ff_00ff_00ff_00ff_00ff_00ff_00ff_807f_5aa5;
  localparam logic [63:0]  OB1_FACTORY = 64'hffff_f00f_0000_0ff0;
  // Flash operation lengths in core_clk cycles
  localparam logic [8:0] PROG_CYCLES      = 9'h010;
  localparam logic [8:0] ERASE_CYCLES     = 9'h040;
  localparam logic [8:0] EXT_ERASE_CYCLES = 9'h100;
  // Core-side software register offsets and operation codes
  localparam logic [4:0] SW_CMD_OFS = 5'h00;
  localparam logic [4:0] SW_IDX_OFS = 5'h04;
  localparam logic [4:0] SW_DLO_OFS = 5'h08;
  localparam logic [4:0] SW_DHI_OFS = 5'h0c;
  localparam logic [4:0] SW_OB1_OFS = 5'h10;
  localparam logic [4:0] SW_RES_OFS = 5'h14;
  localparam logic [1:0] OP_NONE    = 2'h0;
  localparam logic [1:0] OP_ERASE   = 2'h1;
  localparam logic [1:0] OP_PROG    = 2'h2;
  localparam logic [1:0] OP_OB1     = 2'h3;

  typedef enum logic [2:0] {
    DS_IDLE  = 3'h0,
    DS_LOAD  = 3'h1,
    DS_ERASE = 3'h2,
    DS_PROG  = 3'h3,
    DS_EXTER = 3'h4,
    DS_OB1PG = 3'h5
  } obc_dstate_type;

  typedef enum logic [3:0] {
    HS_IDLE = 4'h0, HS_POLL = 4'h1, HS_PCHK = 4'h2, HS_WEN = 4'h3,
    HS_WRD  = 4'h4, HS_WCHK = 4'h5, HS_CMD  = 4'h6, HS_LO  = 4'h7,
    HS_HI   = 4'h8, HS_GO1  = 4'h9, HS_WAIT = 4'ha, HS_WACK = 4'hb,
    HS_RLD  = 4'hc
  } obc_hstate_type;
endpackage

// ---- obc_sva.sv ----
// Assertions on the bus between the core-side driver and the controller
`timescale 1ns/100ps
module obc_sva import obc_pkg::*; (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic [4:0]  regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [31:0] regRdata,
  input wire logic [31:0] dbusAddr,
  input wire logic        dbusWr
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [8:0] eraseLeft;
  logic       armed;
  wire        eraseGo = regWr && regAddr == CTL_OFS && regWdata == (CTL_WEN | CTL_ER | CTL_START);
  wire        statRd  = regRd && regAddr == STAT_OFS;
  // Erase length countdown; armed holds until the flags are cleared
  always_ff @(posedge core_clk) begin
    eraseLeft <= !rst_n ? 9'h000 : eraseGo ? ERASE_CYCLES : eraseLeft - {8'h00, eraseLeft != 9'h000};
    armed     <= rst_n && (eraseGo || (armed && !(regWr && regAddr == STAT_OFS)));
  end
  sequence loWrite;
    dbusWr && !dbusAddr[2];
  endsequence
  chk_rdata_idle: assert property (!$past(regRd) |-> regRdata == 32'h0)
    else $error("read data outside its slot");
  chk_strobe_excl: assert property (!(regWr && regRd))
    else $error("both strobes at once");
  chk_dbus_pair: assert property (loWrite |=> dbusWr && dbusAddr == $past(dbusAddr) + 32'h4)
    else $error("high word not paired");
  chk_dbus_range: assert property (dbusWr |-> dbusAddr[31:5] == OB0_BASE[31:5] && dbusAddr[4:3] != 2'h3)
    else $error("data write outside block");
  chk_erase_busy: assert property (statRd && eraseLeft > 9'h002 |=> regRdata[0])
    else $error("busy low during erase");
  chk_busy_end: assert property ($past(statRd && armed) && !regRdata[0] |-> regRdata[5])
    else $error("idle without end flag");
  chk_start_wen: assert property (regWr && regAddr == CTL_OFS && regWdata[2] |-> regWdata[5])
    else $error("start without write enable");
  chk_stat_bits: assert property ($past(statRd) |-> (regRdata & ~32'h27) == 32'h0)
    else $error("undefined status bits set");
endmodule

// ---- test_option_byte_controller.sv ----
// Self-checking bench for the controller and its core-side driver
`timescale 1ns/100ps
module test_option_byte_controller import obc_pkg::*;;
  logic        core_clk = 1'b0, rst_n = 1'b0, swWr = 1'b0, swRd = 1'b0, bootMain = 1'b0, bank1Void = 1'b0;
  logic [4:0]  swAddr = 5'h00;
  logic [31:0] swWdata = 32'h0, swRdata, obRes, r, seed = 32'h0001_280d;
  logic [7:0]  s, u, bank1ProtectMask, dataflashProtectMask;
  logic        endIrq, bootBank1, copyBank1, standbyNoReset, deepsleepNoReset, watchdogSoftSelect, brownoutEnable;
  logic [1:0]  securityLevel, dataFlashSize;
  logic [31:0] bank0ProtectMask;
  logic [15:0] userData;
  logic [31:0] obv[4] = '{32'h0f20, 32'h0f10, 32'h33cc0f10, 32'h0f00};
  logic [31:0] obExp[4] = '{ST_SEQERR, ST_END, ST_END, ST_SEQERR};
  int          bad_count = 0, cmp_count = 0;
  obc_if bus();
  always #50 core_clk = ~core_clk;
  obc_device u_obc_device(.core_clk, .rst_n, .porRst_n(rst_n), .bus(bus.dev), .bootMain, .bank1Void, .endIrq,
    .bootBank1, .copyBank1, .securityLevel, .standbyNoReset, .deepsleepNoReset, .watchdogSoftSelect,
    .brownoutEnable, .bank0ProtectMask, .bank1ProtectMask, .dataflashProtectMask, .userData, .dataFlashSize);
  obc_core u_obc_core(.core_clk, .rst_n, .bus(bus.core), .swAddr, .swWdata, .swWr, .swRd, .swRdata);
  obc_sva u_obc_sva(.core_clk, .rst_n, .regAddr(bus.regAddr), .regWdata(bus.regWdata), .regWr(bus.regWr),
    .regRd(bus.regRd), .regRdata(bus.regRdata), .dbusAddr(bus.dbusAddr), .dbusWr(bus.dbusWr));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] pairs(input logic [7:0] b0, input logic [7:0] b1);
    return {~b1, b1, ~b0, b0};
  endfunction
  function automatic logic [1:0] secOf(input logic [7:0] v);
    return v == SPC_NONE ? SEC_NONE : v == SPC_HIGH ? SEC_HIGH : SEC_LOW;
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic swWrite(input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk);
    swAddr <= a;
    swWdata <= d;
    swWr <= 1'b1;
    @(posedge core_clk);
    swWr <= 1'b0;
  endtask
  task automatic swRead(input logic [4:0] a, output logic [31:0] d);
    @(posedge core_clk);
    swAddr <= a;
    swRd <= 1'b1;
    @(posedge core_clk);
    swRd <= 1'b0;
    @(negedge core_clk);
    d = swRdata;
  endtask
  task automatic run(input logic [1:0] op, input logic rld);
    logic [31:0] st;
    swWrite(SW_CMD_OFS, {29'h0, rld, op});
    for (int i = 0; i < 3000; i++) begin
      swRead(SW_CMD_OFS, st);
      if (st[0] === 1'b0) break;
    end
    if (st[0] !== 1'b0) bad_count++;
    swRead(SW_RES_OFS, obRes);
    repeat (3) @(posedge core_clk);
  endtask
  task automatic prog(input logic [1:0] idx, input logic [31:0] lo, input logic [31:0] hi, input logic rld);
    swWrite(SW_IDX_OFS, {30'h0, idx});
    swWrite(SW_DLO_OFS, lo);
    swWrite(SW_DHI_OFS, hi);
    run(OP_PROG, rld);
  endtask
  task automatic final_report();
    if (bad_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("security", SEC_NONE, securityLevel);
    chk("bank0 mask", 32'hffffffff, bank0ProtectMask);
    for (int i = 0; i < 5; i++) begin
      r = rnd();
      s = i == 0 ? SPC_NONE : i == 1 ? SPC_HIGH : r[7:0];
      u = r[15:8];
      bootMain <= r[16];
      bank1Void <= r[17];
      run(OP_ERASE, 1'b0);
      chk("erase result", ST_END, obRes);
      prog(2'h0, pairs(s, u), pairs(r[23:16], r[31:24]), 1'b1);
      chk("program result", ST_END, obRes);
      chk("security", secOf(s), securityLevel);
      chk("sleep bits", u[2:1], {standbyNoReset, deepsleepNoReset});
      chk("watchdog", u[0], watchdogSoftSelect);
      chk("brownout", !u[7], brownoutEnable);
      chk("user data", r[31:16], userData);
      chk("copy bank", r[16] && !u[4] && !u[3], copyBank1);
      chk("boot bank", r[16] && u[4] && !u[3] && !r[17], bootBank1);
    end
    prog(2'h0, 32'h0, 32'h0, 1'b0);
    chk("program on used", ST_PROGRAM_ERROR_FLAG, obRes);
    run(OP_ERASE, 1'b0);
    prog(2'h1, 32'hcb341212, pairs(8'h00, 8'h0f), 1'b1);
    chk("bank0 mask", 32'h0f0034ff, bank0ProtectMask);
    chk("security", SEC_LOW, securityLevel);
    chk("bank1 mask", 32'hff, bank1ProtectMask);
    prog(2'h2, pairs(8'h5a, 8'hc3), 32'h0, 1'b1);
    chk("last dword result", ST_END, obRes);
    chk("bank1 mask", 32'h5a, bank1ProtectMask);
    chk("flash mask", 32'hc3, dataflashProtectMask);
    chk("end irq", 32'h0, endIrq);
    for (int i = 0; i < 4; i++) begin
      swWrite(SW_OB1_OFS, obv[i]);
      run(OP_OB1, 1'b0);
      chk("modify result", obExp[i], obRes);
      chk("size before reload", i < 2 ? DF_NONE : DF_32K, dataFlashSize);
      run(OP_NONE, 1'b1);
      chk("size after reload", i < 1 ? DF_NONE : DF_32K, dataFlashSize);
    end
    final_report();
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    bad_count++;
    final_report();
  end
endmodule
